// ### verilog/capcom_defines.svh
// Purpose: register map, field positions and reset values of the capture/compare array unit
// Assumes: 32-bit AXI4-Lite register bus, byte addresses below
// Notes: Function list follows
// Function
// - sixteen channels, one-cycle or eight-cycle resolution
// - two 16-bit time bases with reload registers
// - count clock: prescaler or neighbour overflow
// - external count input advances a time base
// - each register picks time base and function
// - one pin per register, input or output
// - capture loads assigned time base count
// - capture raises that register's interrupt request
// - capture edge: rising, falling or both
// - compare registers match against time base
// - mode zero: interrupt only, repeatable
// - mode one: pin toggles on each match
// - mode two: one interrupt per period
// - mode three: set on match, clear on overflow
// - double register: two registers toggle one pin
// - single event option stops further events
`ifndef CAPCOM_DEFINES_SVH
`define CAPCOM_DEFINES_SVH
`define CC_ADDR_CTRL     8'h00
`define CC_ADDR_TA_CNT   8'h04
`define CC_ADDR_TA_REL   8'h08
`define CC_ADDR_TB_CNT   8'h0C
`define CC_ADDR_TB_REL   8'h10
`define CC_ADDR_PINS     8'h14
`define CC_CFG_PAGE      2'h1
`define CC_VAL_PAGE      2'h2
`define CC_CTRL_RST      32'h0000_0000
`define CC_CTRL_RUN_A    0
`define CC_CTRL_SRC_A    1
`define CC_CTRL_PSEL_A   3
`define CC_CTRL_RUN_B    8
`define CC_CTRL_SRC_B    9
`define CC_CTRL_PSEL_B   11
`define CC_CTRL_STAGGER  16
`define CC_STAGGER_SHIFT 4'h3
`define CC_PRE_W         10
`define CC_RESP_OKAY     2'h0
`define CC_RESP_SLVERR   2'h2
`define CC_NUM_CH        16
`define CC_HALF_CH       8
`endif

// ### verilog/capcom_pkg.sv
// Purpose: types of the capture/compare array unit
// Assumes: capcom_defines.svh holds the numbers
// Notes: channel configuration word is one packed struct
`default_nettype none
package capcom_pkg;
   typedef enum logic [2:0] {
      FN_OFF  = 3'h0,
      FN_CAPT = 3'h1,
      FN_CMP0 = 3'h2,
      FN_CMP1 = 3'h3,
      FN_CMP2 = 3'h4,
      FN_CMP3 = 3'h5
   } chan_func_e;
   typedef enum logic [1:0] {
      SRC_PRESCALE  = 2'h0,
      SRC_NEIGHBOUR = 2'h1,
      SRC_EXTERNAL  = 2'h2
   } count_src_e;
   typedef struct packed {
      logic       dbl;
      logic       single;
      logic       tsel;
      logic [1:0] edge_sel;
      chan_func_e func;
   } chan_cfg_s;
   typedef struct packed {
      logic       run;
      count_src_e src;
      logic [2:0] psel;
   } tmr_ctrl_s;
endpackage
`default_nettype wire

// ### verilog/capture_compare_array_unit.sv
// Purpose: sixteen capture/compare channels on two reloading 16-bit time bases
// Assumes: one clock core_clk, synchronous active-high srst, AXI4-Lite slave
// Notes: pin inputs and external count are synchronised; neighbour overflow is same-domain
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "capcom_defines.svh"
module capture_compare_array_unit
(
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        neighbour_overflow_timer,
   input  wire logic        ext_count_in,
   input  wire logic [15:0] pin_in,
   output logic [15:0]      pin_out,
   output logic [15:0]      pin_oe,
   output logic [15:0]      irq_req
);

   // ==========================================================
   // state
   logic [31:0]                 ctrl_q, ctrl_d;
   logic [15:0]                 tmr_q [2];
   logic [15:0]                 tmr_d [2];
   logic [15:0]                 rel_q [2];
   logic [15:0]                 rel_d [2];
   logic [1:0]                  upd_q, upd_d;
   logic [1:0]                  ovf_q, ovf_d;
   logic [`CC_PRE_W-1:0]        pre_q, pre_d;
   capcom_pkg::chan_cfg_s       cfg_q [`CC_NUM_CH];
   capcom_pkg::chan_cfg_s       cfg_d [`CC_NUM_CH];
   logic [15:0]                 val_q [`CC_NUM_CH];
   logic [15:0]                 val_d [`CC_NUM_CH];
   logic [15:0]                 done_q, done_d;
   logic [15:0]                 spent_q, spent_d;
   logic [15:0]                 pout_q, pout_d;
   logic [15:0]                 irq_q, irq_d;
   logic [15:0]                 pin_m_q, pin_s_q, pin_p_q;
   logic [2:0]                  ext_q;
   logic                        bvalid_q, bvalid_d;
   logic [1:0]                  bresp_q, bresp_d;
   logic                        rvalid_q, rvalid_d;
   logic [1:0]                  rresp_q, rresp_d;
   logic [31:0]                 rdata_q, rdata_d;

   logic                        wr_go, rd_go;
   logic [15:0]                 hit;
   logic                        wr_ch;
   capcom_pkg::tmr_ctrl_s       tc [2];

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ==========================================================
   // bus handshake
   assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
   assign rd_go         = s_axi_arvalid && !rvalid_q;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign pin_out       = pout_q;
   assign irq_req       = irq_q;

   assign tc[0] = capcom_pkg::tmr_ctrl_s'({ctrl_q[`CC_CTRL_RUN_A], ctrl_q[`CC_CTRL_SRC_A +: 2],
                                           ctrl_q[`CC_CTRL_PSEL_A +: 3]});
   assign tc[1] = capcom_pkg::tmr_ctrl_s'({ctrl_q[`CC_CTRL_RUN_B], ctrl_q[`CC_CTRL_SRC_B +: 2],
                                           ctrl_q[`CC_CTRL_PSEL_B +: 3]});

   // ==========================================================
   // time bases and register file
   always_comb
   begin
      logic [3:0]           shift;
      logic [`CC_PRE_W-1:0] mask;
      logic                 tick;
      logic                 hit_wr;
      shift    = 4'h0;
      mask     = '0;
      tick     = 1'b0;
      hit_wr   = 1'b0;
      ctrl_d   = ctrl_q;
      rel_d    = rel_q;
      tmr_d    = tmr_q;
      upd_d    = 2'h0;
      ovf_d    = 2'h0;
      bvalid_d = bvalid_q && !s_axi_bready;
      bresp_d  = bresp_q;
      rvalid_d = rvalid_q && !s_axi_rready;
      rresp_d  = rresp_q;
      rdata_d  = rdata_q;
      pre_d    = pre_q + `CC_PRE_W'(1);
      for (int t = 0; t < 2; t++)
      begin
         shift = {1'b0, tc[t].psel} + (ctrl_q[`CC_CTRL_STAGGER] ? `CC_STAGGER_SHIFT : 4'h0);
         mask  = `CC_PRE_W'((11'h001 << shift) - 11'h001);
         case (tc[t].src)
            capcom_pkg::SRC_PRESCALE:  tick = (pre_q & mask) == mask;
            capcom_pkg::SRC_NEIGHBOUR: tick = neighbour_overflow_timer;
            capcom_pkg::SRC_EXTERNAL:  tick = ext_q[1] && !ext_q[2];
            default:                   tick = 1'b0;
         endcase
         if (tc[t].run && tick)
         begin
            upd_d[t] = 1'b1;
            if (tmr_q[t] == 16'hFFFF)
            begin
               tmr_d[t] = rel_q[t];
               ovf_d[t] = 1'b1;
            end
            else
            begin
               tmr_d[t] = tmr_q[t] + 16'h0001;
            end
         end
      end
      if (wr_go)
      begin
         bvalid_d = 1'b1;
         bresp_d  = `CC_RESP_OKAY;
         if (s_axi_awaddr == `CC_ADDR_CTRL)
         begin
            ctrl_d = merge(ctrl_q, s_axi_wdata, s_axi_wstrb);
         end
         else if (s_axi_awaddr == `CC_ADDR_TA_CNT)
         begin
            tmr_d[0] = 16'(merge({16'h0000, tmr_q[0]}, s_axi_wdata, s_axi_wstrb));
         end
         else if (s_axi_awaddr == `CC_ADDR_TA_REL)
         begin
            rel_d[0] = 16'(merge({16'h0000, rel_q[0]}, s_axi_wdata, s_axi_wstrb));
         end
         else if (s_axi_awaddr == `CC_ADDR_TB_CNT)
         begin
            tmr_d[1] = 16'(merge({16'h0000, tmr_q[1]}, s_axi_wdata, s_axi_wstrb));
         end
         else if (s_axi_awaddr == `CC_ADDR_TB_REL)
         begin
            rel_d[1] = 16'(merge({16'h0000, rel_q[1]}, s_axi_wdata, s_axi_wstrb));
         end
         else if (s_axi_awaddr[7:6] == `CC_CFG_PAGE || s_axi_awaddr[7:6] == `CC_VAL_PAGE)
         begin
            hit_wr = 1'b1;
         end
         else
         begin
            bresp_d = `CC_RESP_SLVERR;
         end
      end
      if (rd_go)
      begin
         rvalid_d = 1'b1;
         rresp_d  = `CC_RESP_OKAY;
         rdata_d  = 32'h0000_0000;
         if (s_axi_araddr == `CC_ADDR_CTRL)
         begin
            rdata_d = ctrl_q;
         end
         else if (s_axi_araddr == `CC_ADDR_TA_CNT)
         begin
            rdata_d = {16'h0000, tmr_q[0]};
         end
         else if (s_axi_araddr == `CC_ADDR_TA_REL)
         begin
            rdata_d = {16'h0000, rel_q[0]};
         end
         else if (s_axi_araddr == `CC_ADDR_TB_CNT)
         begin
            rdata_d = {16'h0000, tmr_q[1]};
         end
         else if (s_axi_araddr == `CC_ADDR_TB_REL)
         begin
            rdata_d = {16'h0000, rel_q[1]};
         end
         else if (s_axi_araddr == `CC_ADDR_PINS)
         begin
            rdata_d = {pout_q, pin_s_q};
         end
         else if (s_axi_araddr[7:6] == `CC_CFG_PAGE)
         begin
            rdata_d = {24'h00_0000, cfg_q[s_axi_araddr[5:2]]};
         end
         else if (s_axi_araddr[7:6] == `CC_VAL_PAGE)
         begin
            rdata_d = {16'h0000, val_q[s_axi_araddr[5:2]]};
         end
         else
         begin
            rresp_d = `CC_RESP_SLVERR;
         end
      end
      wr_ch = hit_wr;
   end

   // ==========================================================
   // channels
   always_comb
   begin
      capcom_pkg::chan_cfg_s c;
      logic                  cap_ev, act;
      logic [3:0]            idx;
      c       = '0;
      cap_ev  = 1'b0;
      act     = 1'b0;
      idx     = s_axi_awaddr[5:2];
      cfg_d   = cfg_q;
      val_d   = val_q;
      done_d  = done_q;
      spent_d = spent_q;
      pout_d  = pout_q;
      irq_d   = 16'h0000;
      hit     = 16'h0000;
      if (wr_ch && s_axi_awaddr[7:6] == `CC_CFG_PAGE && s_axi_wstrb[0])
      begin
         cfg_d[idx]   = capcom_pkg::chan_cfg_s'(s_axi_wdata[7:0]);
         spent_d[idx] = 1'b0;
         done_d[idx]  = 1'b0;
      end
      if (wr_ch && s_axi_awaddr[7:6] == `CC_VAL_PAGE)
      begin
         val_d[idx] = 16'(merge({16'h0000, val_q[idx]}, s_axi_wdata, s_axi_wstrb));
      end
      for (int i = 0; i < `CC_NUM_CH; i++)
      begin
         c = cfg_q[i];
         hit[i] = upd_q[c.tsel] && val_q[i] == tmr_q[c.tsel] && !spent_q[i]
                  && c.func >= capcom_pkg::FN_CMP0 && c.func <= capcom_pkg::FN_CMP3;
      end
      for (int i = 0; i < `CC_NUM_CH; i++)
      begin
         c = cfg_q[i];
         cap_ev = (c.edge_sel[0] && pin_s_q[i] && !pin_p_q[i])
                  || (c.edge_sel[1] && !pin_s_q[i] && pin_p_q[i]);
         act = 1'b0;
         // one event per period, cleared by overflow
         if (ovf_q[c.tsel])
         begin
            done_d[i] = 1'b0;
            if (c.func == capcom_pkg::FN_CMP3)
            begin
               pout_d[i] = 1'b0;
            end
         end
         case (c.func)
            capcom_pkg::FN_CAPT:
            begin
               if (cap_ev && !spent_q[i])
               begin
                  val_d[i] = tmr_q[c.tsel];
                  irq_d[i] = 1'b1;
                  act      = 1'b1;
               end
            end
            capcom_pkg::FN_CMP0:
            begin
               act      = hit[i];
               irq_d[i] = hit[i];
            end
            capcom_pkg::FN_CMP1:
            begin
               act = hit[i];
            end
            capcom_pkg::FN_CMP2:
            begin
               act      = hit[i] && !done_q[i];
               irq_d[i] = act;
            end
            capcom_pkg::FN_CMP3:
            begin
               act = hit[i] && !done_q[i];
               if (act)
               begin
                  pout_d[i] = 1'b1;
               end
            end
            default:
            begin
               act = 1'b0;
            end
         endcase
         // match interrupt in every compare mode
         if (act && c.func != capcom_pkg::FN_CAPT)
         begin
            irq_d[i]  = 1'b1;
            done_d[i] = 1'b1;
         end
         if (c.func == capcom_pkg::FN_CMP1 && act)
         begin
            pout_d[i] = !pout_d[i];
         end
         // partner register toggles the same pin
         if (i < `CC_HALF_CH && c.dbl && hit[i + `CC_HALF_CH])
         begin
            pout_d[i] = !pout_d[i];
         end
         if (act && c.single)
         begin
            spent_d[i] = 1'b1;
         end
      end
      for (int i = 0; i < `CC_NUM_CH; i++)
      begin
         c = cfg_q[i];
         pin_oe[i] = c.func == capcom_pkg::FN_CMP1 || c.func == capcom_pkg::FN_CMP3
                     || (i < `CC_HALF_CH && c.dbl);
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge core_clk)
   begin
      // pin inputs pass two flip-flops first
      pin_m_q <= pin_in;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
      ext_q   <= {ext_q[1:0], ext_count_in};
      if (srst)
      begin
         ctrl_q   <= `CC_CTRL_RST;
         tmr_q    <= '{16'h0000, 16'h0000};
         rel_q    <= '{16'h0000, 16'h0000};
         upd_q    <= 2'h0;
         ovf_q    <= 2'h0;
         pre_q    <= '0;
         cfg_q    <= '{default: '0};
         val_q    <= '{default: 16'h0000};
         done_q   <= 16'h0000;
         spent_q  <= 16'h0000;
         pout_q   <= 16'h0000;
         irq_q    <= 16'h0000;
         bvalid_q <= 1'b0;
         bresp_q  <= `CC_RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q  <= `CC_RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end
      else
      begin
         ctrl_q   <= ctrl_d;
         tmr_q    <= tmr_d;
         rel_q    <= rel_d;
         upd_q    <= upd_d;
         ovf_q    <= ovf_d;
         pre_q    <= pre_d;
         cfg_q    <= cfg_d;
         val_q    <= val_d;
         done_q   <= done_d;
         spent_q  <= spent_d;
         pout_q   <= pout_d;
         irq_q    <= irq_d;
         bvalid_q <= bvalid_d;
         bresp_q  <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q  <= rresp_d;
         rdata_q  <= rdata_d;
      end
   end

endmodule
`default_nettype wire

// ### verif/capcom_properties.sv
// Purpose: port-level checks of the capture/compare array unit
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every instance of the unit
`timescale 1ns/1ps
`default_nettype none
module capcom_properties
(
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        neighbour_overflow_timer,
   input wire logic        ext_count_in,
   input wire logic [15:0] pin_in,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   input wire logic [15:0] irq_req
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);
   // ==========
   // register bus
   a_aw_ready_eq: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
      else $error("write ready does not follow the handshake");
   a_ar_ready_eq: assert property (s_axi_arready == (s_axi_arvalid && !s_axi_rvalid))
      else $error("read ready does not follow read valid");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
      else $error("write response late");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped");
   // ==========
   // pins and requests
   a_reset_quiet: assert property ($fell(srst) |-> irq_req == 16'h0000 && pin_out == 16'h0000)
      else $error("outputs active after reset");
   a_pin_driven: assert property (((pin_out ^ $past(pin_out)) & ~$past(pin_oe)) == 16'h0000)
      else $error("pin changed while not driven");
endmodule
bind capture_compare_array_unit capcom_properties i_capcom_properties
(
   .core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .neighbour_overflow_timer, .ext_count_in, .pin_in, .pin_out, .pin_oe, .irq_req
);
`default_nettype wire

// ### verif/pin_source.sv
// Purpose: external sources on the port pins, count input and neighbour timer
// Assumes: the bench calls the tasks just after a rising edge
// Notes: levels change only right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module pin_source
(
   input  wire logic        core_clk,
   output logic [15:0]      pin_in,
   output logic             ext_count_in,
   output logic             neighbour_overflow_timer
);
   initial
   begin
      pin_in = 16'h0000;
      ext_count_in = 1'h0;
      neighbour_overflow_timer = 1'h0;
   end
   // one-cycle overflow pulse in the core clock domain
   task automatic nb_pulse();
      @(posedge core_clk);
      neighbour_overflow_timer <= 1'h1;
      @(posedge core_clk);
      neighbour_overflow_timer <= 1'h0;
   endtask
   // pin levels held long enough to pass the synchroniser
   task automatic set_pin(input int i, input logic v);
      @(posedge core_clk);
      pin_in[i] <= v;
      repeat (6) @(posedge core_clk);
   endtask
   task automatic ext_pulse();
      @(posedge core_clk);
      ext_count_in <= 1'h1;
      repeat (4) @(posedge core_clk);
      ext_count_in <= 1'h0;
      repeat (4) @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

// ### verif/capture_compare_array_unit_tb.sv
// Purpose: self-checking bench of the capture/compare array unit
// Assumes: AXI4-Lite master tasks, pin source model for the far side
// Notes: neighbour pulses step timer A one count at a time
`timescale 1ns/1ps
`default_nettype none
`include "capcom_defines.svh"
module capture_compare_array_unit_tb;
   logic        core_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        neighbour_overflow_timer, ext_count_in;
   logic [15:0] pin_in, pin_out, pin_oe, irq_req;
   int          n_mismatch = 0, num_checks = 0, cyc = 0, take_cyc, b, t0, e;
   int          irq_cnt [16] = '{default: 0};

   capture_compare_array_unit i_capture_compare_array_unit
   (
      .core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .neighbour_overflow_timer, .ext_count_in, .pin_in, .pin_out, .pin_oe, .irq_req
   );
   pin_source i_pin_source (.core_clk, .pin_in, .ext_count_in, .neighbour_overflow_timer);

   initial
   begin
      core_clk = 1'h0;
      forever #25 core_clk = ~core_clk;
   end
   // ==========
   // cycle count, request pulses, hang limit
   always @(posedge core_clk)
   begin
      cyc++;
      foreach (irq_cnt[i]) if (irq_req[i] === 1'h1) irq_cnt[i]++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         stop_test();
      end
   end
   // ==========
   // tasks
   task automatic stop_test();
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = `CC_RESP_OKAY);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do @(posedge core_clk); while (s_axi_awready !== 1'h1);
      take_cyc = cyc;
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      s_axi_bready <= 1'h1;
      do @(posedge core_clk); while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk("bresp", 32'(s_axi_bresp), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge core_clk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      s_axi_rready <= 1'h1;
      do @(posedge core_clk); while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   function automatic logic [7:0] ch(input logic [1:0] pg, input int i);
      return {pg, 4'(i), 2'h0};
   endfunction
   function automatic logic [31:0] cfg(input logic [2:0] f, input logic [1:0] eg, input logic t, s, dl);
      return {24'h0, dl, s, t, eg, f};
   endfunction
   // timer A from 4 to 5 by one neighbour pulse
   task automatic match();
      wr(`CC_ADDR_TA_CNT, 32'h4);
      i_pin_source.nb_pulse();
      repeat (4) @(posedge core_clk);
   endtask
   // ==========
   // main sequence
   initial
   begin
      srst = 1'h1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      repeat (5) @(posedge core_clk);
      srst <= 1'h0;
      @(posedge core_clk);
      rd(`CC_ADDR_CTRL); chk("ctrl", d, `CC_CTRL_RST);
      rd(8'h3C); chk("rresp", 32'(r), 32'(`CC_RESP_SLVERR));
      chk("rdata", d, 32'h0);
      wr(8'h3C, 32'h1, `CC_RESP_SLVERR);
      wr(`CC_ADDR_TA_CNT, 32'h12345);
      rd(`CC_ADDR_TA_CNT); chk("count", d, 32'h2345);
      wr(`CC_ADDR_TA_REL, 32'h1234);
      wr(`CC_ADDR_TA_CNT, 32'hFFFF);
      wr(`CC_ADDR_CTRL, 32'h503);
      for (int k = 0; k < 2; k++)
      begin
         i_pin_source.nb_pulse();
         rd(`CC_ADDR_TA_CNT); chk("reload", d, 32'h1234 + k);
      end
      wr(`CC_ADDR_TB_CNT, 32'h0);
      repeat (3) i_pin_source.ext_pulse();
      rd(`CC_ADDR_TB_CNT); chk("ext count", d, 32'h3);
      // compare modes 0..3 on channel 1, two matches in one period
      wr(ch(`CC_VAL_PAGE, 1), 32'h5);
      for (int m = 0; m < 4; m++)
      begin
         wr(ch(`CC_CFG_PAGE, 1), cfg(3'(2 + m), 2'h0, 1'h0, 1'h0, 1'h0));
         b = irq_cnt[1];
         for (int k = 0; k < 2; k++)
         begin
            match();
            chk("pin", 32'(pin_out[1]), 32'(8'hC4 >> (2 * m + k) & 8'h1));
         end
         chk("oe", 32'(pin_oe[1]), 32'(m % 2));
         if (m < 3) chk("irq", irq_cnt[1] - b, (m == 2) ? 1 : 2);
      end
      wr(`CC_ADDR_TA_REL, 32'h0);
      wr(`CC_ADDR_TA_CNT, 32'hFFFF);
      i_pin_source.nb_pulse();
      repeat (4) @(posedge core_clk);
      chk("ovf clear", 32'(pin_out[1]), 32'h0);
      wr(ch(`CC_CFG_PAGE, 1), cfg(capcom_pkg::FN_CMP1, 2'h0, 1'h0, 1'h1, 1'h0));
      match();
      match();
      chk("single", 32'(pin_out[1]), 32'h1);
      // channel 10 toggles pin 2
      wr(ch(`CC_VAL_PAGE, 10), 32'h5);
      wr(ch(`CC_CFG_PAGE, 10), cfg(capcom_pkg::FN_CMP0, 2'h0, 1'h0, 1'h0, 1'h0));
      wr(ch(`CC_CFG_PAGE, 2), cfg(capcom_pkg::FN_OFF, 2'h0, 1'h0, 1'h0, 1'h1));
      for (int k = 0; k < 2; k++)
      begin
         match();
         chk("double", 32'(pin_out[2]), 32'(k == 0));
      end
      chk("double oe", 32'(pin_oe[2]), 32'h1);
      rd(`CC_ADDR_PINS); chk("pins", d, 32'h0002_0000);
      // capture on timer B: rising, falling, both
      for (int eg = 1; eg < 4; eg++)
      begin
         wr(`CC_ADDR_TB_CNT, 32'hA0 + eg);
         wr(ch(`CC_CFG_PAGE, 3), cfg(capcom_pkg::FN_CAPT, 2'(eg), 1'h1, 1'h0, 1'h0));
         b = irq_cnt[3];
         i_pin_source.set_pin(3, 1'h1);
         i_pin_source.set_pin(3, 1'h0);
         chk("capture irq", irq_cnt[3] - b, (eg == 3) ? 2 : 1);
         rd(ch(`CC_VAL_PAGE, 3)); chk("captured", d, 32'hA0 + eg);
      end
      // prescale every cycle, then staggered every eight
      for (int s = 0; s < 2; s++)
      begin
         wr(`CC_ADDR_TA_CNT, 32'h0);
         wr(`CC_ADDR_CTRL, s ? 32'h10001 : 32'h1);
         t0 = take_cyc;
         repeat (s ? 80 : 20) @(posedge core_clk);
         wr(`CC_ADDR_CTRL, 32'h0);
         rd(`CC_ADDR_TA_CNT);
         e = (take_cyc - t0) >> (3 * s);
         chk("rate", 32'(int'(d) >= e - 1 && int'(d) <= e + 1), 32'h1);
      end
      stop_test();
   end
endmodule
`default_nettype wire
